// >>> tw_params.svh
// Constants of the two-wire data buffer and slave address block.
// Assumes a 32-bit APB with byte addresses and one word per register.
`ifndef TW_PARAMS_SVH
`define TW_PARAMS_SVH
// Byte offsets of the register words.
`define TW_OFS_DATA 8'h00
`define TW_OFS_MODE 8'h04
`define TW_OFS_CTRL 8'h08
`define TW_OFS_STAT 8'h0C
`define TW_OFS_IRQ 8'h10
`define TW_OFS_MASK 8'h14
// Control bits.
`define TW_CTL_ICE 0
`define TW_CTL_TRS 1
// Mode register fields.
`define TW_MODE_MLS 7
`define TW_MODE_BC_HI 2
// Interrupt bits; the status register shares only bits 0 and 1.
`define TW_EV_TXE 0
`define TW_EV_RXF 1
`define TW_EV_ADR 2
`define TW_EV_STP 3
// Reset values.
`define TW_RST_BYTE 8'h00
`define TW_RST_CTRL 2'h0
`define TW_RST_EV 4'h0
// Format select codes, primary bit then second bit.
`define TW_FMT_BOTH 2'b00
`define TW_FMT_PRIM 2'b01
`define TW_FMT_SEC 2'b10
`define TW_FMT_SYNC 2'b11
// Data bits in a frame when the bit count field is zero.
`define TW_FULL_BITS 4'h8
`endif

// >>> tw_pkg.sv
// Types of the two-wire data buffer and slave address block.
// Assumes tw_params.svh is on the include path.
package tw_pkg;
   typedef enum logic [2:0]
   {
      TW_IDLE = 3'b001,
      TW_ADDR = 3'b010,
      TW_DATA = 3'b100
   } tw_state_t;
endpackage

// >>> tw_link_if.sv
// Bus events passed from the pin front end to the data buffer core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface tw_link_if;
   logic sclRise;
   logic sclFall;
   logic startDet;
   logic stopDet;
   logic sdaLvl;
   modport front
   (
      output sclRise, sclFall, startDet, stopDet, sdaLvl
   );
   modport core
   (
      input sclRise, sclFall, startDet, stopDet, sdaLvl
   );
endinterface

// >>> tw_link_front.sv
// Pin synchroniser and edge, start and stop detector for the serial bus.
// Assumes the serial clock is far slower than clk.
`timescale 1ns/1ps
module tw_link_front
   import tw_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic sys_rst,
   // Bus pins.
   input wire logic sclPin,
   input wire logic sdaPin,
   // Events to the core.
   tw_link_if.front lnk
);
   logic [2:0] scl_ff;
   logic [2:0] sda_ff;
   logic [2:0] nxt_scl;
   logic [2:0] nxt_sda;

   ////////////////////////////////////////////////////////////////////////
   // Bit 0 is only read by bit 1; edges use bits 1 and 2.
   always_comb
   begin
      nxt_scl = {scl_ff[1:0], sclPin};
      nxt_sda = {sda_ff[1:0], sdaPin};
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         scl_ff <= 3'h7;
         sda_ff <= 3'h7;
      end
      else
      begin
         scl_ff <= nxt_scl;
         sda_ff <= nxt_sda;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign lnk.sclRise = scl_ff[1] & ~scl_ff[2];
   assign lnk.sclFall = ~scl_ff[1] & scl_ff[2];
   assign lnk.startDet = scl_ff[1] & scl_ff[2] & ~sda_ff[1] & sda_ff[2];
   assign lnk.stopDet = scl_ff[1] & scl_ff[2] & sda_ff[1] & ~sda_ff[2];
   assign lnk.sdaLvl = sda_ff[1];
endmodule

// >>> tw_data_buf.sv
// Top of the two-wire data buffer with slave address match and APB.
// Assumes an APB master on clk and open-drain pins resolved outside.
`timescale 1ns/1ps
`include "tw_params.svh"
module tw_data_buf
   import tw_pkg::*;
#(
   parameter int FRAME_BITS = 8
)
(
   // Clock and reset.
   input wire logic clk,
   input wire logic sys_rst,
   // APB slave.
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial bus pins.
   input wire logic sclPin,
   input wire logic sdaPin,
   output logic sdaOut,
   output logic sdaOe,
   // Interrupt.
   output logic irq
);
   if (FRAME_BITS != 8)
   begin : gChk
      $error("FRAME_BITS must be 8");
   end

   function automatic logic [7:0] shiftIn(logic [7:0] v, logic b,
                                          logic lsbFirst);
      shiftIn = lsbFirst ? {b, v[7:1]} : {v[6:0], b};
   endfunction

   function automatic logic addrHit(logic [6:0] a, logic [7:0] p,
                                    logic [7:0] s);
      logic hp;
      logic hs;
      hp = a == p[7:1];
      hs = a == s[7:1];
      case ({p[0], s[0]})
         `TW_FMT_BOTH: addrHit = hp | hs;
         `TW_FMT_PRIM: addrHit = hp;
         `TW_FMT_SEC: addrHit = hs;
         default: addrHit = 1'b0;
      endcase
   endfunction

   tw_link_if lnk();

   tw_link_front tw_link_front_inst
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .sclPin(sclPin),
      .sdaPin(sdaPin),
      .lnk(lnk)
   );

   ////////////////////////////////////////////////////////////////////////
   // Register side.
   logic [1:0] ctrl_ff, nxt_ctrl;
   logic [7:0] mode_ff, nxt_mode;
   logic [7:0] sar_ff, nxt_sar;
   logic [7:0] second_slave_address_ff, nxt_second_slave_address;
   logic [7:0] txBuf_ff, nxt_txBuf;
   logic [3:0] mask_ff, nxt_mask;
   logic [31:0] prdata_ff, nxt_prdata;
   logic pready_ff, nxt_pready;
   logic pslverr_ff, nxt_pslverr;
   // Link side.
   tw_state_t state_ff, nxt_state;
   logic [7:0] shift_ff, nxt_shift;
   logic [7:0] rxBuf_ff, nxt_rxBuf;
   logic [3:0] bitCnt_ff, nxt_bitCnt;
   logic txEmpty_ff, nxt_txEmpty;
   logic rxFull_ff, nxt_rxFull;
   logic startSeen_ff, nxt_startSeen;
   logic trsPrev_ff, nxt_trsPrev;
   logic [3:0] sts_ff, nxt_sts;
   logic irq_ff, nxt_irq;
   logic sdaOe_ff, nxt_sdaOe;
   logic frameDone, txLoad, rxLoad, txSet, txClr;
   logic [3:0] frameLen;
   logic [7:0] shifted;

   logic acc, wr, rd, iface_enable, transmit_mode_select, bit_order_select, syncFmt, trsRise;
   logic txWrite, rxRead, irqWrite;

   assign acc = psel & penable & pready_ff;
   assign wr = acc & pwrite;
   assign rd = acc & ~pwrite;
   assign iface_enable = ctrl_ff[`TW_CTL_ICE];
   assign transmit_mode_select = ctrl_ff[`TW_CTL_TRS];
   assign bit_order_select = mode_ff[`TW_MODE_MLS];
   assign syncFmt = {sar_ff[0], second_slave_address_ff[0]} == `TW_FMT_SYNC;
   assign trsRise = transmit_mode_select & ~trsPrev_ff;
   assign txWrite = wr & iface_enable & paddr == `TW_OFS_DATA;
   assign rxRead = rd & iface_enable & ~transmit_mode_select & paddr == `TW_OFS_DATA;
   assign irqWrite = wr & paddr == `TW_OFS_IRQ;

   ////////////////////////////////////////////////////////////////////////
   // APB: one wait state, answer registered in the access phase.
   always_comb
   begin
      nxt_ctrl = ctrl_ff;
      nxt_mode = mode_ff;
      nxt_sar = sar_ff;
      nxt_second_slave_address = second_slave_address_ff;
      nxt_txBuf = txBuf_ff;
      nxt_mask = mask_ff;
      nxt_prdata = prdata_ff;
      nxt_pslverr = pslverr_ff;
      nxt_pready = psel & penable & ~pready_ff;
      if (psel & penable & ~pready_ff)
      begin
         nxt_pslverr = 1'b0;
         nxt_prdata = 32'h0000_0000;
         case (paddr)
            // The enable picks one register of each pair.
            `TW_OFS_DATA: nxt_prdata[7:0] = iface_enable ? rxBuf_ff : second_slave_address_ff;
            `TW_OFS_MODE: nxt_prdata[7:0] = iface_enable ? mode_ff : sar_ff;
            `TW_OFS_CTRL: nxt_prdata[1:0] = ctrl_ff;
            `TW_OFS_STAT:
               nxt_prdata[3:0] = {state_ff == TW_DATA, startSeen_ff,
                                  rxFull_ff, txEmpty_ff};
            `TW_OFS_IRQ: nxt_prdata[3:0] = sts_ff;
            `TW_OFS_MASK: nxt_prdata[3:0] = mask_ff;
            default: nxt_pslverr = 1'b1;
         endcase
      end
      if (wr)
      begin
         case (paddr)
            `TW_OFS_DATA:
               if (iface_enable)
                  nxt_txBuf = pwdata[7:0];
               else
                  nxt_second_slave_address = pwdata[7:0];
            `TW_OFS_MODE:
               if (iface_enable)
                  nxt_mode = pwdata[7:0];
               else
                  nxt_sar = pwdata[7:0];
            `TW_OFS_CTRL: nxt_ctrl = pwdata[1:0];
            `TW_OFS_MASK: nxt_mask = pwdata[3:0];
            default: nxt_ctrl = ctrl_ff;
         endcase
      end
   end

   // The data buffer is cleared only so simulation stays free of unknowns;
   // software must not count on it.
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ctrl_ff <= `TW_RST_CTRL;
         mode_ff <= `TW_RST_BYTE;
         sar_ff <= `TW_RST_BYTE;
         second_slave_address_ff <= `TW_RST_BYTE;
         txBuf_ff <= `TW_RST_BYTE;
         mask_ff <= `TW_RST_EV;
         prdata_ff <= 32'h0000_0000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end
      else
      begin
         ctrl_ff <= nxt_ctrl;
         mode_ff <= nxt_mode;
         sar_ff <= nxt_sar;
         second_slave_address_ff <= nxt_second_slave_address;
         txBuf_ff <= nxt_txBuf;
         mask_ff <= nxt_mask;
         prdata_ff <= nxt_prdata;
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Link side. The acknowledge bit is not handled here; frames are data
   // bits only, so the shift register wraps straight into the next frame.
   always_comb
   begin
      nxt_state = state_ff;
      nxt_shift = shift_ff;
      nxt_rxBuf = rxBuf_ff;
      nxt_bitCnt = bitCnt_ff;
      nxt_startSeen = startSeen_ff;
      nxt_trsPrev = transmit_mode_select;
      nxt_sdaOe = sdaOe_ff;
      frameDone = 1'b0;
      txLoad = 1'b0;
      rxLoad = 1'b0;
      frameLen = mode_ff[`TW_MODE_BC_HI:0] == 3'h0 ? `TW_FULL_BITS :
                 {1'b0, mode_ff[`TW_MODE_BC_HI:0]};
      shifted = shiftIn(shift_ff, lnk.sdaLvl, bit_order_select);
      case (state_ff)
         TW_IDLE: nxt_bitCnt = 4'h0;
         TW_ADDR, TW_DATA:
            if (lnk.sclRise)
            begin
               nxt_shift = shifted;
               nxt_bitCnt = bitCnt_ff + 4'h1;
               if (bitCnt_ff + 4'h1 == frameLen)
               begin
                  frameDone = 1'b1;
                  nxt_bitCnt = 4'h0;
                  nxt_state = TW_DATA;
               end
            end
         default: nxt_state = TW_IDLE;
      endcase
      // SDA may move only while SCL is low, or a false start or stop shows.
      if (state_ff == TW_IDLE || !transmit_mode_select)
         nxt_sdaOe = 1'b0;
      else if (lnk.sclFall)
         nxt_sdaOe = ~(bit_order_select ? shift_ff[0] : shift_ff[7]);
      if (frameDone && transmit_mode_select && !txEmpty_ff)
      begin
         txLoad = 1'b1;
         nxt_shift = txBuf_ff;
      end
      if (frameDone && !transmit_mode_select && !rxFull_ff)
      begin
         rxLoad = 1'b1;
         nxt_rxBuf = shifted;
      end
      if (lnk.startDet)
      begin
         nxt_state = syncFmt ? TW_DATA : TW_ADDR;
         nxt_bitCnt = 4'h0;
         nxt_startSeen = 1'b1;
      end
      else if (lnk.stopDet)
      begin
         nxt_state = TW_IDLE;
         nxt_startSeen = 1'b0;
      end
      if (!iface_enable)
      begin
         nxt_state = TW_IDLE;
         nxt_startSeen = 1'b0;
      end
      // A set in the same cycle as a clear wins.
      txSet = (lnk.startDet & transmit_mode_select) | (trsRise & syncFmt) | txLoad |
              (trsRise & startSeen_ff);
      txClr = (txWrite & transmit_mode_select) | lnk.stopDet | ~transmit_mode_select;
      nxt_txEmpty = txSet | (txEmpty_ff & ~txClr);
      nxt_rxFull = rxLoad | (rxFull_ff & ~rxRead);
      // Events are sticky; writing a one clears, a new event wins.
      nxt_sts = sts_ff & ~(irqWrite ? pwdata[3:0] : 4'h0);
      nxt_sts[`TW_EV_TXE] = nxt_sts[`TW_EV_TXE] | (txSet & ~txEmpty_ff);
      nxt_sts[`TW_EV_RXF] = nxt_sts[`TW_EV_RXF] | rxLoad;
      nxt_sts[`TW_EV_ADR] = nxt_sts[`TW_EV_ADR] |
         (frameDone & state_ff == TW_ADDR & !syncFmt &
          addrHit(shifted[7:1], sar_ff, second_slave_address_ff));
      nxt_sts[`TW_EV_STP] = nxt_sts[`TW_EV_STP] | lnk.stopDet;
      nxt_irq = |(nxt_sts & mask_ff);
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_ff <= TW_IDLE;
         shift_ff <= `TW_RST_BYTE;
         rxBuf_ff <= `TW_RST_BYTE;
         bitCnt_ff <= 4'h0;
         txEmpty_ff <= 1'b0;
         rxFull_ff <= 1'b0;
         startSeen_ff <= 1'b0;
         trsPrev_ff <= 1'b0;
         sts_ff <= `TW_RST_EV;
         irq_ff <= 1'b0;
         sdaOe_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         shift_ff <= nxt_shift;
         rxBuf_ff <= nxt_rxBuf;
         bitCnt_ff <= nxt_bitCnt;
         txEmpty_ff <= nxt_txEmpty;
         rxFull_ff <= nxt_rxFull;
         startSeen_ff <= nxt_startSeen;
         trsPrev_ff <= nxt_trsPrev;
         sts_ff <= nxt_sts;
         irq_ff <= nxt_irq;
         sdaOe_ff <= nxt_sdaOe;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign irq = irq_ff;
   assign sdaOe = sdaOe_ff;
   // The pin is open drain: it is only ever pulled low.
   assign sdaOut = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence apbSetup;
      psel & ~penable;
   endsequence
   sequence apbAccess;
      psel & penable & ~pready_ff;
   endsequence

   AST_APB_WAIT: assert property
      (apbSetup ##1 apbAccess |=> pready_ff)
      else $error("answer not given one cycle into access");
   AST_TX_LOAD: assert property
      (frameDone & transmit_mode_select & ~txEmpty_ff |=>
       txEmpty_ff & shift_ff == $past(txBuf_ff))
      else $error("transmit buffer not moved to shifter");
   AST_RX_LOAD: assert property
      (frameDone & ~transmit_mode_select & ~rxFull_ff |=>
       rxFull_ff & rxBuf_ff == $past(shifted))
      else $error("shifter not moved to receive buffer");
   AST_RX_CLR: assert property
      (rxRead & ~rxLoad |=> ~rxFull_ff)
      else $error("receive flag not cleared by read");
   AST_TX_CLR: assert property
      (~transmit_mode_select & ~txSet |=> ~txEmpty_ff)
      else $error("tx empty set in receive mode");
   AST_SAR_HIDE: assert property
      (wr & iface_enable & paddr == `TW_OFS_MODE |=> $stable(sar_ff))
      else $error("hidden address register written");
   AST_DATA_HIDE: assert property
      (wr & ~iface_enable & paddr == `TW_OFS_DATA |=> $stable(txBuf_ff))
      else $error("data port written while disabled");
   AST_EV_RXF: assert property
      ($rose(rxFull_ff) |-> sts_ff[`TW_EV_RXF])
      else $error("rx full rise left no event");
   AST_SYNC_FMT: assert property
      (iface_enable & syncFmt & lnk.startDet |=>
       (state_ff == TW_DATA & ~sts_ff[`TW_EV_ADR]) [*2])
      else $error("synchronous format went through addressing");
endmodule

// >>> tw_bus_master_model.sv
// Behavioural serial bus master that frames traffic for the block.
// Assumes a pull-up on SDA, resolved by the bench from both drivers.
`timescale 1ns/1ps
module tw_bus_master_model
(
   // Bus lines.
   output logic sclLine,
   output logic sdaPull,
   input wire logic sdaWire
);
   // SCL stands high between frames, so the block sees no stray edges.
   initial
   begin
      sclLine = 1'b1;
      sdaPull = 1'b0;
   end
   task automatic startCond();
   begin
      sdaPull = 1'b0;
      #40 sdaPull = 1'b1;
      #40;
   end
   endtask
   task automatic stopCond();
   begin
      sclLine = 1'b0;
      sdaPull = 1'b1;
      #40 sclLine = 1'b1;
      #40 sdaPull = 1'b0;
      #80;
   end
   endtask
   // Data changes only while SCL is low; a listening master lets SDA go.
   task automatic frame(input int nBits, input logic [7:0] val,
      input logic lsbFirst, input logic listen, output logic [7:0] got);
      logic b;
   begin
      got = 8'h00;
      for (int i = 0; i < nBits; i++)
      begin
         b = lsbFirst ? val[i] : val[nBits - 1 - i];
         sclLine = 1'b0;
         #20 sdaPull = !listen && !b;
         #20 got = {got[6:0], sdaWire};
         sclLine = 1'b1;
         #40;
      end
   end
   endtask
endmodule

// >>> tw_data_buf_tb_top.sv
// Self-checking bench for the data buffer and slave address block.
// Assumes the design files and tw_params.svh are compiled first.
`timescale 1ns/1ps
`include "tw_params.svh"
module tw_data_buf_tb_top;
   logic clk;
   logic sysRst;
   logic [7:0] paddr;
   logic psel;
   logic penable;
   logic pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic sdaOut;
   logic sdaOe;
   logic irq;
   logic sclLine;
   logic sdaPull;
   logic sdaWire;
   logic [31:0] rdv;
   logic errv;
   logic [7:0] got;
   int nMismatch = 0;
   int checksDone = 0;
   int cycles = 0;
   assign sdaWire = !(sdaPull || (sdaOe && !sdaOut));
   tw_data_buf #(.FRAME_BITS(8)) tw_data_buf_inst
   (
      .clk(clk), .sys_rst(sysRst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sclPin(sclLine), .sdaPin(sdaWire), .sdaOut(sdaOut),
      .sdaOe(sdaOe), .irq(irq)
   );
   tw_bus_master_model bm
   (
      .sclLine(sclLine), .sdaPull(sdaPull), .sdaWire(sdaWire)
   );
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // A hung handshake must still reach the verdict.
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         nMismatch++;
         conclude();
      end
   end
   ////////////////////////////////////////////////////////////////
   task automatic conclude();
   begin
      $display("comparisons %0d mismatches %0d", checksDone, nMismatch);
      if (nMismatch == 0 && checksDone > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   end
   endtask
   task automatic chk(input logic [31:0] exp, input logic [31:0] gotv);
   begin
      checksDone++;
      if (gotv !== exp)
      begin
         nMismatch++;
         $display("wrong value at %0t: expected %h got %h", $time, exp,
            gotv);
      end
   end
   endtask
   // The request is held until pready is seen high at a rising edge.
   task automatic xfer(input logic [7:0] a, input logic w,
      input logic [31:0] d);
   begin
      @(posedge clk);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      penable <= 1'b0;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // Only the cycle ceiling ends a wait that never sees pready.
      while (pready !== 1'b1)
         @(posedge clk);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
   begin
      xfer(a, 1'b0, 32'h0);
      chk(exp, rdv);
   end
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic testRegs();
   begin
      rdChk(`TW_OFS_DATA, 32'h0);
      rdChk(`TW_OFS_MODE, 32'h0);
      xfer(`TW_OFS_DATA, 1'b1, 32'hFFFFFFA5);
      xfer(`TW_OFS_MODE, 1'b1, 32'h5C);
      rdChk(`TW_OFS_DATA, 32'hA5);
      rdChk(`TW_OFS_MODE, 32'h5C);
      xfer(8'h20, 1'b0, 32'h0);
      chk(32'h1, {31'h0, errv});
      xfer(`TW_OFS_CTRL, 1'b1, 32'h1);
      rdChk(`TW_OFS_MODE, 32'h0);
      xfer(`TW_OFS_CTRL, 1'b1, 32'h0);
      rdChk(`TW_OFS_MODE, 32'h5C);
      $display("test regs done");
   end
   endtask
   task automatic testRx();
   begin
      xfer(`TW_OFS_CTRL, 1'b1, 32'h1);
      xfer(`TW_OFS_MASK, 1'b1, 32'hF);
      bm.startCond();
      bm.frame(8, 8'h5C, 1'b0, 1'b0, got);
      xfer(`TW_OFS_IRQ, 1'b0, 32'h0);
      chk(32'h1, {31'h0, rdv[2]});
      // The address frame lands in the free receive buffer as well.
      rdChk(`TW_OFS_DATA, 32'h5C);
      bm.frame(8, 8'h3A, 1'b0, 1'b0, got);
      xfer(`TW_OFS_STAT, 1'b0, 32'h0);
      chk(32'h1, {31'h0, rdv[1]});
      chk(32'h1, {31'h0, irq});
      rdChk(`TW_OFS_DATA, 32'h3A);
      xfer(`TW_OFS_STAT, 1'b0, 32'h0);
      chk(32'h0, {31'h0, rdv[1]});
      bm.stopCond();
      xfer(`TW_OFS_IRQ, 1'b1, 32'hF);
      // The clear lands at the edge that ends the write; look one later.
      @(posedge clk);
      chk(32'h0, {31'h0, irq});
      $display("test rx done");
   end
   endtask
   task automatic testMiss();
   begin
      bm.startCond();
      bm.frame(8, 8'hA4, 1'b0, 1'b0, got);
      bm.stopCond();
      xfer(`TW_OFS_IRQ, 1'b0, 32'h0);
      chk(32'h0, {31'h0, rdv[2]});
      // Empty the receive buffer so that the next frame can land in it.
      rdChk(`TW_OFS_DATA, 32'hA4);
      xfer(`TW_OFS_IRQ, 1'b1, 32'hF);
      $display("test miss done");
   end
   endtask
   // Four bits LSB-first in the synchronous format land at the MSB end.
   task automatic testShortLsb();
   begin
      xfer(`TW_OFS_CTRL, 1'b1, 32'h0);
      xfer(`TW_OFS_MODE, 1'b1, 32'h5D);
      xfer(`TW_OFS_CTRL, 1'b1, 32'h1);
      xfer(`TW_OFS_MODE, 1'b1, 32'h84);
      bm.startCond();
      bm.frame(4, 8'h0B, 1'b1, 1'b0, got);
      bm.stopCond();
      xfer(`TW_OFS_IRQ, 1'b0, 32'h0);
      chk(32'h1, {30'h0, rdv[2:1]});
      xfer(`TW_OFS_DATA, 1'b0, 32'h0);
      chk(32'hB, {28'h0, rdv[7:4]});
      xfer(`TW_OFS_IRQ, 1'b1, 32'hF);
      $display("test short lsb done");
   end
   endtask
   task automatic testTx();
   begin
      xfer(`TW_OFS_MODE, 1'b1, 32'h0);
      xfer(`TW_OFS_CTRL, 1'b1, 32'h3);
      xfer(`TW_OFS_STAT, 1'b0, 32'h0);
      chk(32'h1, {31'h0, rdv[0]});
      // A start in transmit mode empties the buffer, so data goes in after.
      bm.startCond();
      xfer(`TW_OFS_DATA, 1'b1, 32'h96);
      xfer(`TW_OFS_STAT, 1'b0, 32'h0);
      chk(32'h0, {31'h0, rdv[0]});
      xfer(`TW_OFS_IRQ, 1'b1, 32'hF);
      bm.frame(8, 8'h00, 1'b0, 1'b1, got);
      xfer(`TW_OFS_STAT, 1'b0, 32'h0);
      chk(32'h1, {31'h0, rdv[0]});
      chk(32'h1, {31'h0, irq});
      bm.frame(8, 8'h00, 1'b0, 1'b1, got);
      chk(32'h96, {24'h0, got});
      bm.stopCond();
      $display("test tx done");
   end
   endtask
   ////////////////////////////////////////////////////////////////
   initial
   begin
      sysRst = 1'b1;
      paddr = 8'h00;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      pwdata = 32'h0;
      repeat (5) @(posedge clk);
      sysRst <= 1'b0;
      testRegs();
      testRx();
      testMiss();
      testShortLsb();
      testTx();
      conclude();
   end
endmodule
